// ===== design/rci_defs.vh
/*
 * Constants for the reset-cause and interrupt block: register offsets,
 * field positions, reset values and vectors.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef RCI_DEFS_VH
`define RCI_DEFS_VH

// register byte offsets on the axi4-lite slave
`define RCI_OFS_STATUS 4'h0
`define RCI_OFS_MASK 4'h4
`define RCI_OFS_CAUSE 4'h8
`define RCI_OFS_CTRL 4'hC

// interrupt status and mask field positions
`define RCI_BIT_TIMER 0
`define RCI_BIT_PORTCHG 1
`define RCI_BIT_EXT 2

// reset-cause field positions
`define RCI_BIT_PINWAKE 0
`define RCI_BIT_WDTO 1
`define RCI_BIT_PWRDN 2

// control register field positions
`define RCI_BIT_PORTSEL 0
`define RCI_BIT_EXTSEL 6

// reset values
`define RCI_RST_FLAGS 3'h0
`define RCI_RST_MASK 3'h0

// fetch vectors
`define RCI_VEC_HW 10'h008
`define RCI_VEC_SW 10'h001

// bus response codes
`define RCI_RESP_OKAY 2'h0
`define RCI_RESP_SLVERR 2'h2

`endif

// ===== design/rci_reset_irq.v
/*
 * Reset-cause recorder and three-source interrupt controller, with an
 * axi4-lite register slave.
 * Assumes the core gives one-cycle instruction strobes, all inputs are
 * synchronous to clk, and the core handles its own restart at reset.
 */
`timescale 1ns/1ns
`include "rci_defs.vh"

module rci_reset_irq (
    // clock and reset
    input wire clk,
    input wire sys_rst,
    // reset causes, level during the reset
    input wire power_on_rst,
    input wire reset_pin_n,
    input wire watchdog_timeout,
    // core instruction strobes
    input wire watchdog_clear_instr,
    input wire sleep_instr,
    input wire irq_enable_instr,
    input wire irq_disable_instr,
    input wire irq_return_instr,
    input wire sw_irq_instr,
    // interrupt sources
    input wire timer_counter_ovf,
    input wire [5:0] port_in,
    // core fetch redirect and sleep control
    output wire vector_valid,
    output reg [9:0] vector_addr,
    output reg sleeping,
    output wire wake,
    output wire irq_req,
    // axi4-lite slave
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);

    reg [2:0] irq_status_reg;
    reg [2:0] irq_mask_reg;
    reg [2:0] cause;
    reg global_en;
    reg [5:0] port_is_out;
    reg port_zero_is_int;
    reg [5:0] port_ref;
    reg [5:0] port_prev;
    reg timer_prev;
    reg vec_pulse;
    reg [3:0] aw_addr;
    reg aw_held;
    reg [31:0] w_data;
    reg w_held;
    reg [2:0] next_irq_status;
    reg [2:0] next_cause;
    reg [31:0] rd_word;
    reg [5:0] chg_bits;
    wire [5:0] excluded;
    wire port_change;
    wire ext_fall;
    wire timer_fall;
    wire wr_fire;
    wire [3:0] wr_addr;
    wire [31:0] wr_data;
    wire wr_status;
    wire [5:0] port_zero_mask;

    // exclusion of outputs and of pin zero serving as interrupt input
    assign port_zero_mask = {5'b0_0000, port_zero_is_int};
    assign excluded = port_is_out | port_zero_mask;

    // per-pin compare against the stored port image
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi = gi + 1) begin : g_chg
            always @* begin
                chg_bits[gi] = (port_in[gi] ^ port_ref[gi]) & ~excluded[gi];
            end
        end
    endgenerate
    assign port_change = |chg_bits;

    // falling edges of the other two sources
    assign ext_fall = port_prev[0] & ~port_in[0] & port_zero_is_int;
    assign timer_fall = timer_prev & ~timer_counter_ovf;

    // masked request and wake; branching needs the global enable
    assign irq_req = |(irq_status_reg & irq_mask_reg);
    assign wake = sleeping &
        (port_change & irq_mask_reg[`RCI_BIT_PORTCHG]);
    assign vector_valid = vec_pulse;

    // bus write channel: either order, response after both
    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready = ~w_held & ~s_axi_bvalid;
    assign wr_fire = (aw_held | s_axi_awvalid) & (w_held | s_axi_wvalid) &
        ~s_axi_bvalid;
    assign wr_addr = aw_held ? aw_addr : s_axi_awaddr;
    assign wr_data = w_held ? w_data : s_axi_wdata;
    assign wr_status = wr_fire & (wr_addr == `RCI_OFS_STATUS) &
        s_axi_wstrb[0];
    assign s_axi_arready = ~s_axi_rvalid;

    // next status: hardware sets win over software zero-writes
    always @* begin
        next_irq_status = irq_status_reg;
        if (wr_status) begin
            next_irq_status = irq_status_reg & wr_data[2:0];
        end
        if (timer_fall) begin
            next_irq_status[`RCI_BIT_TIMER] = 1'b1;
        end
        if (ext_fall) begin
            next_irq_status[`RCI_BIT_EXT] = 1'b1;
        end
        // port change only latches while its mask bit is set
        if (port_change & irq_mask_reg[`RCI_BIT_PORTCHG]) begin
            next_irq_status[`RCI_BIT_PORTCHG] = 1'b1;
        end
    end

    // reset-cause update: each cause picks its flag pattern
    always @* begin
        next_cause = cause;
        if (power_on_rst) begin
            next_cause = 3'b110;
        end else if (watchdog_timeout) begin
            if (sleeping) begin
                next_cause = 3'b000;
            end else begin
                next_cause = {cause[`RCI_BIT_PWRDN], 2'b00};
            end
        end else if (!reset_pin_n) begin
            if (sleeping) begin
                next_cause = 3'b010;
            end else begin
                next_cause = {cause[2:1], 1'b0};
            end
        end else if (wake) begin
            next_cause = 3'b011;
        end else if (watchdog_clear_instr) begin
            next_cause = {2'b11, cause[0]};
        end else if (sleep_instr) begin
            next_cause = {2'b01, cause[0]};
        end
    end

    // cause flags survive sys_rst; power-on sets them to 110, other causes, wake and strobes rewrite them
    always @(posedge clk) begin
        cause <= next_cause;
    end

    // interrupt state, sleep and vectoring
    always @(posedge clk) begin
        if (sys_rst | power_on_rst | ~reset_pin_n | watchdog_timeout) begin
            irq_status_reg <= `RCI_RST_FLAGS;
            irq_mask_reg <= `RCI_RST_MASK;
            global_en <= 1'b0;
            sleeping <= 1'b0;
            vec_pulse <= 1'b0;
            vector_addr <= `RCI_VEC_HW;
            port_is_out <= 6'b00_0000;
            port_zero_is_int <= 1'b0;
            port_ref <= 6'b00_0000;
            port_prev <= 6'b00_0000;
            timer_prev <= 1'b0;
        end else begin
            irq_status_reg <= next_irq_status;
            port_prev <= port_in;
            timer_prev <= timer_counter_ovf;
            vec_pulse <= 1'b0;
            // reference tracks pins while change detection is off
            if (!irq_mask_reg[`RCI_BIT_PORTCHG] | wake) begin
                port_ref <= port_in;
            end
            if (sleep_instr) begin
                sleeping <= 1'b1;
            end else if (wake) begin
                sleeping <= 1'b0;
            end
            if (irq_enable_instr | irq_return_instr) begin
                global_en <= 1'b1;
            end else if (irq_disable_instr) begin
                global_en <= 1'b0;
            end
            // software interrupt outranks a pending hardware one
            if (sw_irq_instr & global_en) begin
                vec_pulse <= 1'b1;
                vector_addr <= `RCI_VEC_SW;
                global_en <= 1'b0;
            end else if (global_en & irq_req & ~irq_return_instr &
                    ~irq_enable_instr) begin
                vec_pulse <= 1'b1;
                vector_addr <= `RCI_VEC_HW;
                global_en <= 1'b0;
            end
            if (wr_fire & s_axi_wstrb[0]) begin
                if (wr_addr == `RCI_OFS_MASK) begin
                    irq_mask_reg <= wr_data[2:0];
                end
                if (wr_addr == `RCI_OFS_CTRL) begin
                    port_is_out <= wr_data[5:0];
                    port_zero_is_int <= wr_data[`RCI_BIT_EXTSEL];
                end
            end
        end
    end

    // read mux
    always @* begin
        rd_word = 32'h0000_0000;
        case (s_axi_araddr)
            `RCI_OFS_STATUS: rd_word = {29'h0, irq_status_reg};
            `RCI_OFS_MASK: rd_word = {29'h0, irq_mask_reg};
            `RCI_OFS_CAUSE: rd_word = {29'h0, cause};
            `RCI_OFS_CTRL: rd_word = {25'h0, port_zero_is_int, port_is_out};
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // axi handshakes; unmapped offsets answer slverr
    always @(posedge clk) begin
        if (sys_rst) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 4'h0;
            w_data <= 32'h0000_0000;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RCI_RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `RCI_RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
        end else begin
            if (s_axi_awvalid & s_axi_awready & ~wr_fire) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready & ~wr_fire) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
            end
            if (wr_fire) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr_addr == `RCI_OFS_STATUS ||
                    wr_addr == `RCI_OFS_MASK || wr_addr == `RCI_OFS_CTRL) ?
                    `RCI_RESP_OKAY : `RCI_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= (s_axi_araddr[1:0] == 2'b00) ?
                    `RCI_RESP_OKAY : `RCI_RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule // rci_reset_irq

// ===== tb/rci_asserts.sv
/* checker on rci_reset_irq ports: vectors, sleep, enable.
   assumes one clock domain; bound below to every instance. */
`timescale 1ns/1ns
`include "rci_defs.vh"
module rci_asserts (
    // clock and resets
    input wire clk,
    input wire sys_rst,
    input wire power_on_rst,
    // core strobes
    input wire sleep_instr,
    input wire sw_irq_instr,
    input wire irq_enable_instr,
    input wire irq_disable_instr,
    input wire irq_return_instr,
    // outputs to the core
    input wire vector_valid,
    input wire [9:0] vector_addr,
    input wire sleeping,
    input wire wake,
    input wire irq_req
);
    // which vector is being taken
    wire hw = vector_valid && vector_addr == `RCI_VEC_HW;
    wire sw = vector_valid && vector_addr == `RCI_VEC_SW;
    wire en = irq_enable_instr || irq_return_instr;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // each vector tied to its cause one cycle back
    property p_hw; hw |-> $past(irq_req); endproperty
    a_hw: assert property (p_hw) else $error("hw vector");
    property p_sw; sw |-> $past(sw_irq_instr); endproperty
    a_sw: assert property (p_sw) else $error("sw vector");
    property p_one; vector_valid |=> !vector_valid; endproperty
    a_one: assert property (p_one) else $error("nested");
    property p_dis; irq_disable_instr ##1 !en |=> !vector_valid; endproperty
    a_dis: assert property (p_dis) else $error("disabled");
    // sleep entry, wake and power-on clearing
    property p_slp; sleep_instr && !wake |=> sleeping; endproperty
    a_slp: assert property (p_slp) else $error("no sleep");
    property p_wk; wake |-> sleeping; endproperty
    a_wk: assert property (p_wk) else $error("wake awake");
    property p_wke; wake && !sleep_instr |=> !sleeping; endproperty
    a_wke: assert property (p_wke) else $error("still asleep");
    property p_por; power_on_rst |=> !irq_req && !sleeping; endproperty
    a_por: assert property (p_por) else $error("por state");
endmodule // rci_asserts
bind rci_reset_irq rci_asserts rci_asserts_i (.*);

// ===== tb/rci_core_model.sv
/* core model: takes each fetch redirect and counts it.
   assumes vector_valid is a one-cycle pulse. */
`timescale 1ns/1ns
module rci_core_model (
    // clock and reset
    input wire clk,
    input wire sys_rst,
    // redirect in, fetch record out
    input wire vector_valid,
    input wire [9:0] vector_addr,
    output reg [9:0] fetch_addr,
    output reg [7:0] n_fetch
);
    // a redirect is honoured only in its pulse cycle
    always @(posedge clk) begin
        if (sys_rst) begin
            n_fetch <= 8'h00;
        end else if (vector_valid) begin
            fetch_addr <= vector_addr;
            n_fetch <= n_fetch + 8'h01;
        end
    end
endmodule // rci_core_model

// ===== tb/rci_reset_irq_tb_top.sv
/* bench for rci_reset_irq: causes, wake, vectors, bus.
   assumes design, core model and checker built first. */
`timescale 1ns/1ns
`include "rci_defs.vh"
module rci_reset_irq_tb_top;
    logic clk = 0, sys_rst = 1, power_on_rst = 1, timer_counter_ovf = 0;
    logic reset_pin_n = 1, watchdog_timeout = 0, s_axi_awvalid = 0;
    logic s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, vector_valid, sleeping, wake;
    logic irq_req;
    logic [5:0] ins = 0, port_in = 0;
    logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, q;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [9:0] vector_addr, fetch_addr;
    logic [7:0] n_fetch;
    int fails = 0, n_tests = 0, cyc = 0;
    rci_reset_irq rci_reset_irq_i (.*, .s_axi_wstrb(4'hf),
        .watchdog_clear_instr(ins[0]), .sleep_instr(ins[1]),
        .irq_enable_instr(ins[2]), .irq_disable_instr(ins[3]),
        .irq_return_instr(ins[4]), .sw_irq_instr(ins[5]));
    rci_core_model rci_core_model_i (.*);
    // clock, and a cycle ceiling against hangs
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails++;
            stop_test;
        end
    end
    task stop_test;
        $display("tests %0d fails %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one cycle of {watchdog, pin reset, core strobes}
    task ev(input logic [7:0] v);
        @(posedge clk) {watchdog_timeout, reset_pin_n, ins} <= v ^ 8'h40;
        @(posedge clk) {watchdog_timeout, reset_pin_n, ins} <= 8'h40;
    endtask
    // one axi4-lite transfer; a read compares with d, a write wants okay
    // waits for the answer as long as it takes; only the ceiling stops it
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
        {s_axi_arvalid, s_axi_rready} <= {2{!w}};
        while (1) begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_arready) s_axi_arvalid <= 0;
            // error reads compare the code, not the data
            q = w ? {30'h0, s_axi_bresp} : s_axi_rresp !== 0 ?
                {s_axi_rresp, 30'h0} : s_axi_rdata;
            if (s_axi_bvalid || s_axi_rvalid) begin
                {s_axi_bready, s_axi_rready} <= 2'b00;
                break;
            end
        end
        if (!w) chk(q, d);
        else chk(q, {30'h0, `RCI_RESP_OKAY});
    endtask
    // each reset cause while awake, the two cause instructions, then pin and watchdog reset asleep
    task t_cause;
        bus(0, 4'h8, 32'h6);
        bus(0, 4'h4, 32'h0);
        ev(8'h80);
        bus(0, 4'h8, 32'h4);
        ev(8'h40);
        bus(0, 4'h8, 32'h4);
        ev(8'h01);
        bus(0, 4'h8, 32'h6);
        ev(8'h02);
        bus(0, 4'h8, 32'h2);
        ev(8'h40);
        bus(0, 4'h8, 32'h2);
        chk(sleeping, 0);
        ev(8'h02);
        ev(8'h80);
        bus(0, 4'h8, 32'h0);
    endtask
    // pin change wakes the core; output pins do not; global enable off
    task t_wake;
        bus(1, 4'h4, 32'h2); // pins steady since read
        bus(1, 4'hc, 32'h4);
        ev(8'h02);
        port_in <= 6'h04;
        repeat (4) @(posedge clk);
        chk(sleeping, 1);
        bus(1, 4'hc, 32'h0);
        repeat (2) @(posedge clk);
        chk(sleeping, 0);
        bus(0, 4'h8, 32'h3);
        bus(0, 4'h0, 32'h2);
        chk(n_fetch, 0);
        bus(1, 4'h4, 32'h0);
        bus(1, 4'h0, 32'h0);
    endtask
    // latch, mask, vector, return, software entry
    task t_irq;
        timer_counter_ovf <= 1;
        bus(0, 4'h0, 32'h0);
        timer_counter_ovf <= 0;
        repeat (3) @(posedge clk);
        bus(0, 4'h0, 32'h1);
        chk(irq_req, 0);
        bus(1, 4'h4, 32'h1);
        chk(irq_req, 1);
        ev(8'h04);
        repeat (4) @(posedge clk);
        chk(fetch_addr, `RCI_VEC_HW);
        chk(n_fetch, 1);
        bus(1, 4'h0, 32'h0); // cleared before return
        ev(8'h10);
        ev(8'h20);
        repeat (3) @(posedge clk);
        chk(fetch_addr, `RCI_VEC_SW);
        ev(8'h04);
        ev(8'h08);
        ev(8'h20);
        bus(1, 4'hc, 32'h40);
        port_in <= 6'h01;
        bus(0, 4'h8, 32'h3);
        port_in <= 6'h00;
        repeat (3) @(posedge clk);
        bus(0, 4'h0, 32'h4);
        chk(n_fetch, 2);
        bus(0, 4'h2, 32'h8000_0000);
    endtask
    // reset with power applied, scenarios, verdict
    initial begin
        repeat (10) @(posedge clk);
        sys_rst <= 0;
        @(posedge clk) power_on_rst <= 0;
        t_cause;
        t_wake;
        t_irq;
        stop_test;
    end
endmodule // rci_reset_irq_tb_top
